// ==== lib_pkg.sv ====
// constants, codes and carriers shared by the logic input block
package lib_pkg;
    localparam int NUM_LOGIC = 20;
    localparam int NUM_CONTACT = 14;
    localparam int SEL_W = 5;
    localparam int NUM_FUNC = 48;
    localparam int NUM_OC_STAGE = 14;
    localparam int NUM_ELEM = 13;
    localparam logic [SEL_W-1:0] SEL_DISABLED = 5'h00;
    localparam logic [SEL_W-1:0] SEL_MAX = 5'h14;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_VIRT = 12'h004;
    localparam logic [11:0] OFS_LSTAT = 12'h008;
    localparam logic [11:0] OFS_FACT_LO = 12'h00c;
    localparam logic [11:0] OFS_FACT_HI = 12'h010;
    localparam logic [11:0] OFS_SETUP = 12'h020;
    localparam logic [11:0] OFS_FSEL = 12'h040;
    localparam int SETUP_REGS = 5;
    localparam int FSEL_REGS = 12;
    localparam int CTRL_MOD_BIT = 0;
    localparam logic CTRL_RST = 1'b0;
    localparam logic [NUM_LOGIC-1:0] VIRT_RST = 20'h00000;
    localparam logic [SEL_W-1:0] SETUP_RST = 5'h00;
    localparam logic [SEL_W-1:0] FSEL_RST = 5'h00;
    // function indices into the selector table
    localparam int F_TRIP = 0;
    localparam int F_CLOSE = 1;
    localparam int F_ELEM0 = 2;
    localparam int F_SYNC_BYP = 10;
    localparam int F_STATS = 11;
    localparam int F_REV_PWR = 15;
    localparam int F_OC_ALL = 16;
    localparam int F_OC_STAGE0 = 21;
    localparam int F_SRC1_CLOSED = 35;
    localparam int F_SRC2_CLOSED = 36;
    localparam int F_CPL_CLOSE1 = 37;
    localparam int F_CPL_CLOSE2 = 38;
    localparam int F_TIE_CONN = 39;
    localparam int F_TIE_CLOSED = 40;
    localparam int F_XFMR_LOCK = 41;
    localparam int F_SRC_TRIP = 42;
    localparam int F_XFER_BLK = 43;
    localparam int F_RC_INIT = 44;
    localparam int F_RC_CANCEL = 45;
    localparam int F_RC_BLOCK = 46;
    localparam int F_SIM_FAULT = 47;
    typedef enum logic [4:0] {CMB_OFF, CMB_CCL, CMB_COP, CMB_VON, CMB_VOFF,
        CMB_CCL_AND_V, CMB_CCL_AND_NV, CMB_COP_AND_V, CMB_COP_AND_NV,
        CMB_CCL_OR_V, CMB_CCL_OR_NV, CMB_COP_OR_V, CMB_COP_OR_NV,
        CMB_CCL_XOR_V, CMB_CCL_XOR_NV, CMB_COP_XOR_V, CMB_COP_XOR_NV} lib_comb_e;
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
    } lib_ahb_req_s;
    typedef struct packed {
        logic tripRelay;
        logic closeRelay;
        logic [NUM_ELEM-1:0] elemInhibit;
        logic reversePowerInhibit;
        logic [NUM_OC_STAGE-1:0] ocInhibit;
        logic breakerStatsFreeze;
        logic [1:0] sourceBreakerClosedState;
        logic tieClosed;
        logic couplerCloseRequest;
        logic transferInhibit;
        logic transferInitiate;
        logic recloseInitiate;
        logic recloseAbort;
        logic faultForce;
    } lib_out_s;
endpackage

// ==== lib_logic_input_block.sv ====
// logic input assignment and block/initiate gating with an ahb-lite register slave
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module lib_logic_input_block (
    input wire logic mclk,
    input wire logic reset,
    input wire lib_pkg::lib_ahb_req_s ahbReq,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [lib_pkg::NUM_CONTACT-1:0] contactPin,
    input wire logic tripDemand,
    input wire logic closeDemand,
    input wire logic syncCheckOk,
    input wire logic simTestMode,
    input wire logic breakerClosed,
    input wire logic prefaultState,
    output lib_pkg::lib_out_s gateOut
);
    logic [lib_pkg::NUM_CONTACT-1:0] contactMeta_r;
    logic [lib_pkg::NUM_CONTACT-1:0] contactSync_r;
    logic modEnable_r;
    logic [lib_pkg::NUM_LOGIC-1:0] virt_r;
    logic [lib_pkg::SEL_W-1:0] setup_r [lib_pkg::NUM_LOGIC];
    logic [lib_pkg::SEL_W-1:0] fsel_r [lib_pkg::NUM_FUNC];
    logic [lib_pkg::NUM_LOGIC-1:0] logicIn;
    logic [lib_pkg::NUM_FUNC-1:0] fnActive;
    logic wrPend_r;
    logic rdPend_r;
    logic [11:0] addr_r;
    logic [31:0] rdWord;
    logic accept;
    logic xferInhibit;
    logic rcAbort;

    function automatic logic combine(input logic [4:0] code, input logic c, input logic v,
                                     input logic hasContact);
        logic r;
        r = 1'b0;
        unique case (lib_pkg::lib_comb_e'(code))
            lib_pkg::CMB_OFF: r = 1'b0;
            lib_pkg::CMB_CCL: r = c;
            lib_pkg::CMB_COP: r = ~c;
            lib_pkg::CMB_VON: r = v;
            lib_pkg::CMB_VOFF: r = ~v;
            lib_pkg::CMB_CCL_AND_V: r = c & v;
            lib_pkg::CMB_CCL_AND_NV: r = c & ~v;
            lib_pkg::CMB_COP_AND_V: r = ~c & v;
            lib_pkg::CMB_COP_AND_NV: r = ~c & ~v;
            lib_pkg::CMB_CCL_OR_V: r = c | v;
            lib_pkg::CMB_CCL_OR_NV: r = c | ~v;
            lib_pkg::CMB_COP_OR_V: r = ~c | v;
            lib_pkg::CMB_COP_OR_NV: r = ~c | ~v;
            lib_pkg::CMB_CCL_XOR_V: r = c ^ v;
            lib_pkg::CMB_CCL_XOR_NV: r = c ^ ~v;
            lib_pkg::CMB_COP_XOR_V: r = ~c ^ v;
            lib_pkg::CMB_COP_XOR_NV: r = ~c ^ ~v;
            default: r = 1'b0;
        endcase
        // inputs without a contact accept only the two virtual codes
        if (!hasContact && code != lib_pkg::CMB_VON && code != lib_pkg::CMB_VOFF)
        begin
            r = 1'b0;
        end
        return r;
    endfunction

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            contactMeta_r <= '0;
            contactSync_r <= '0;
        end
        else
        begin
            contactMeta_r <= contactPin;
            contactSync_r <= contactMeta_r;
        end
    end

    always_comb
    begin
        for (int i = 0; i < lib_pkg::NUM_LOGIC; i++)
        begin
            if (i < lib_pkg::NUM_CONTACT)
            begin
                logicIn[i] = combine(setup_r[i], contactSync_r[i], virt_r[i], 1'b1);
            end
            else
            begin
                logicIn[i] = combine(setup_r[i], 1'b0, virt_r[i], 1'b0);
            end
        end
    end

    // any number of functions may name the same input
    always_comb
    begin
        for (int f = 0; f < lib_pkg::NUM_FUNC; f++)
        begin
            fnActive[f] = 1'b0;
            if (fsel_r[f] != lib_pkg::SEL_DISABLED && fsel_r[f] <= lib_pkg::SEL_MAX)
            begin
                fnActive[f] = logicIn[fsel_r[f] - 5'h01];
            end
        end
    end

    // an unassigned tie-connected input means the breaker is taken as usable
    assign xferInhibit = fnActive[lib_pkg::F_XFER_BLK]
        | (fsel_r[lib_pkg::F_TIE_CONN] != lib_pkg::SEL_DISABLED
           & ~fnActive[lib_pkg::F_TIE_CONN]);
    assign rcAbort = fnActive[lib_pkg::F_RC_CANCEL] | fnActive[lib_pkg::F_RC_BLOCK];

    // gating recomputed every cycle, nothing is latched
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            gateOut <= '0;
        end
        else
        begin
            gateOut.tripRelay <= tripDemand & ~fnActive[lib_pkg::F_TRIP];
            gateOut.closeRelay <= closeDemand & ~fnActive[lib_pkg::F_CLOSE]
                & (syncCheckOk | fnActive[lib_pkg::F_SYNC_BYP]);
            for (int e = 0; e < lib_pkg::NUM_ELEM; e++)
            begin
                gateOut.elemInhibit[e] <= fnActive[lib_pkg::F_ELEM0 + e];
            end
            gateOut.reversePowerInhibit <= modEnable_r & fnActive[lib_pkg::F_REV_PWR];
            for (int s = 0; s < lib_pkg::NUM_OC_STAGE; s++)
            begin
                // stages 0-3 phase, 4-7 neutral, 8-9 ground, 10-11 sensitive, 12-13 neg seq
                gateOut.ocInhibit[s] <= fnActive[lib_pkg::F_OC_ALL]
                    | (s < 4 && fnActive[lib_pkg::F_OC_ALL + 1])
                    | (s >= 4 && s < 8 && fnActive[lib_pkg::F_OC_ALL + 2])
                    | (s >= 8 && s < 10 && fnActive[lib_pkg::F_OC_ALL + 3])
                    | (s >= 10 && s < 12 && fnActive[lib_pkg::F_OC_ALL + 4])
                    | fnActive[lib_pkg::F_OC_STAGE0 + s];
            end
            gateOut.breakerStatsFreeze <= fnActive[lib_pkg::F_STATS];
            gateOut.sourceBreakerClosedState <= {fnActive[lib_pkg::F_SRC2_CLOSED],
                                                 fnActive[lib_pkg::F_SRC1_CLOSED]};
            gateOut.tieClosed <= fnActive[lib_pkg::F_TIE_CLOSED];
            gateOut.couplerCloseRequest <= ~xferInhibit
                & (fnActive[lib_pkg::F_CPL_CLOSE1] | fnActive[lib_pkg::F_CPL_CLOSE2]);
            gateOut.transferInhibit <= xferInhibit;
            gateOut.transferInitiate <= ~xferInhibit
                & (fnActive[lib_pkg::F_XFMR_LOCK] | fnActive[lib_pkg::F_SRC_TRIP]);
            gateOut.recloseInitiate <= fnActive[lib_pkg::F_RC_INIT] & ~rcAbort;
            gateOut.recloseAbort <= rcAbort;
            gateOut.faultForce <= simTestMode & breakerClosed & prefaultState
                & fnActive[lib_pkg::F_SIM_FAULT];
        end
    end

    // bus slave: writes take no wait state, reads take one so hrdata is registered
    assign accept = ahbReq.hsel & ahbReq.htrans[1] & hready;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wrPend_r <= 1'b0;
            rdPend_r <= 1'b0;
            addr_r <= '0;
            hreadyout <= 1'b1;
            hrdata <= '0;
            hresp <= 1'b0;
        end
        else
        begin
            wrPend_r <= accept & ahbReq.hwrite;
            rdPend_r <= accept & ~ahbReq.hwrite;
            hreadyout <= ~(accept & ~ahbReq.hwrite);
            if (accept)
            begin
                addr_r <= {ahbReq.haddr[11:2], 2'b00};
            end
            if (rdPend_r)
            begin
                hrdata <= rdWord;
            end
            hresp <= 1'b0;
        end
    end

    always_comb
    begin
        rdWord = '0;
        if (addr_r == lib_pkg::OFS_CTRL)
        begin
            rdWord[lib_pkg::CTRL_MOD_BIT] = modEnable_r;
        end
        if (addr_r == lib_pkg::OFS_VIRT)
        begin
            rdWord[lib_pkg::NUM_LOGIC-1:0] = virt_r;
        end
        if (addr_r == lib_pkg::OFS_LSTAT)
        begin
            rdWord[lib_pkg::NUM_LOGIC-1:0] = logicIn;
        end
        if (addr_r == lib_pkg::OFS_FACT_LO)
        begin
            rdWord = fnActive[31:0];
        end
        if (addr_r == lib_pkg::OFS_FACT_HI)
        begin
            rdWord[lib_pkg::NUM_FUNC-33:0] = fnActive[lib_pkg::NUM_FUNC-1:32];
        end
        for (int k = 0; k < lib_pkg::SETUP_REGS; k++)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (addr_r == lib_pkg::OFS_SETUP + 12'(4 * k))
                begin
                    rdWord[8*b +: lib_pkg::SEL_W] = setup_r[4*k + b];
                end
            end
        end
        for (int k = 0; k < lib_pkg::FSEL_REGS; k++)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (addr_r == lib_pkg::OFS_FSEL + 12'(4 * k))
                begin
                    rdWord[8*b +: lib_pkg::SEL_W] = fsel_r[4*k + b];
                end
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            modEnable_r <= lib_pkg::CTRL_RST;
            virt_r <= lib_pkg::VIRT_RST;
            for (int i = 0; i < lib_pkg::NUM_LOGIC; i++)
            begin
                setup_r[i] <= lib_pkg::SETUP_RST;
            end
            for (int f = 0; f < lib_pkg::NUM_FUNC; f++)
            begin
                fsel_r[f] <= lib_pkg::FSEL_RST;
            end
        end
        else if (wrPend_r)
        begin
            if (addr_r == lib_pkg::OFS_CTRL)
            begin
                modEnable_r <= ahbReq.hwdata[lib_pkg::CTRL_MOD_BIT];
            end
            if (addr_r == lib_pkg::OFS_VIRT)
            begin
                virt_r <= ahbReq.hwdata[lib_pkg::NUM_LOGIC-1:0];
            end
            for (int k = 0; k < lib_pkg::SETUP_REGS; k++)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (addr_r == lib_pkg::OFS_SETUP + 12'(4 * k))
                    begin
                        setup_r[4*k + b] <= ahbReq.hwdata[8*b +: lib_pkg::SEL_W];
                    end
                end
            end
            for (int k = 0; k < lib_pkg::FSEL_REGS; k++)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (addr_r == lib_pkg::OFS_FSEL + 12'(4 * k))
                    begin
                        fsel_r[4*k + b] <= ahbReq.hwdata[8*b +: lib_pkg::SEL_W];
                    end
                end
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_closeHeld;
        closeDemand && fnActive[lib_pkg::F_CLOSE];
    endsequence
    sequence s_statsDrop;
        fnActive[lib_pkg::F_STATS] ##1 !fnActive[lib_pkg::F_STATS];
    endsequence

    property p_disabledTrip;
        tripDemand && fsel_r[lib_pkg::F_TRIP] == lib_pkg::SEL_DISABLED |=> gateOut.tripRelay;
    endproperty
    a_disabledTrip: assert property (p_disabledTrip) else $error("disabled block acted");
    property p_elemBlock;
        fnActive[lib_pkg::F_ELEM0 + 1] |=> gateOut.elemInhibit[1];
    endproperty
    a_elemBlock: assert property (p_elemBlock) else $error("element not inhibited");
    property p_tripOnly;
        tripDemand && fnActive[lib_pkg::F_TRIP] && !fnActive[lib_pkg::F_ELEM0]
            |=> !gateOut.tripRelay && !gateOut.elemInhibit[0];
    endproperty
    a_tripOnly: assert property (p_tripOnly) else $error("trip block misbehaved");
    property p_closeBlock;
        s_closeHeld |=> !gateOut.closeRelay;
    endproperty
    a_closeBlock: assert property (p_closeBlock) else $error("close not blocked");
    property p_syncBypass;
        closeDemand && !fnActive[lib_pkg::F_CLOSE] && !syncCheckOk
            && fnActive[lib_pkg::F_SYNC_BYP] |=> gateOut.closeRelay;
    endproperty
    a_syncBypass: assert property (p_syncBypass) else $error("bypass ignored");
    property p_statsRelease;
        s_statsDrop |=> !gateOut.breakerStatsFreeze;
    endproperty
    a_statsRelease: assert property (p_statsRelease) else $error("freeze stuck");
    property p_revPower;
        !modEnable_r |=> !gateOut.reversePowerInhibit;
    endproperty
    a_revPower: assert property (p_revPower) else $error("reverse power without mod");
    property p_ocAll;
        fnActive[lib_pkg::F_OC_ALL] |=> &gateOut.ocInhibit;
    endproperty
    a_ocAll: assert property (p_ocAll) else $error("overcurrent not all blocked");
    property p_xferBlock;
        fnActive[lib_pkg::F_XFER_BLK]
            |=> !gateOut.transferInitiate && !gateOut.couplerCloseRequest;
    endproperty
    a_xferBlock: assert property (p_xferBlock) else $error("transfer not disabled");
    property p_rcAbort;
        rcAbort |=> gateOut.recloseAbort && !gateOut.recloseInitiate;
    endproperty
    a_rcAbort: assert property (p_rcAbort) else $error("reclose not aborted");
    property p_simFault;
        !simTestMode || !prefaultState |=> !gateOut.faultForce;
    endproperty
    a_simFault: assert property (p_simFault) else $error("fault forced outside test");
    property p_virtOnly;
        setup_r[lib_pkg::NUM_CONTACT] == 5'h01 |-> !logicIn[lib_pkg::NUM_CONTACT];
    endproperty
    a_virtOnly: assert property (p_virtOnly) else $error("contact code on input 15");
    property p_readWait;
        accept && !ahbReq.hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_readWait: assert property (p_readWait) else $error("read timing wrong");
endmodule // lib_logic_input_block
`default_nettype wire

// ==== lib_far_model.sv ====
// far-side model: external contacts, breaker conditions and protection demands
`timescale 1ns/10ps
`default_nettype none
module lib_far_model (
    input wire logic mclk,
    input wire logic [13:0] contactWant,
    input wire logic [5:0] condWant,
    output logic [13:0] contactPin,
    output logic tripDemand,
    output logic closeDemand,
    output logic syncCheckOk,
    output logic simTestMode,
    output logic breakerClosed,
    output logic prefaultState
);
    initial
    begin
        contactPin = 14'h0000;
        {tripDemand, closeDemand, syncCheckOk, simTestMode, breakerClosed, prefaultState} = 6'h00;
    end
    // real contacts move off the clock grid, so the block's synchroniser sees them mid-cycle
    always @(contactWant) contactPin <= #7 contactWant;
    always @(posedge mclk)
    begin
        {tripDemand, closeDemand, syncCheckOk,
            simTestMode, breakerClosed, prefaultState} <= condWant;
    end
endmodule // lib_far_model
`default_nettype wire

// ==== lib_testbench.sv ====
// self-checking bench for the logic input gating block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic mclk, reset, hready, hreadyout, hresp;
    lib_pkg::lib_ahb_req_s ahbReq;
    logic [31:0] hrdata;
    logic [13:0] contactWant, contactPin;
    logic [5:0] condWant;
    logic tripDemand, closeDemand, syncCheckOk, simTestMode, breakerClosed, prefaultState;
    lib_pkg::lib_out_s gateOut;
    logic [4:0] selSh [68];
    logic [19:0] virtSh;
    int errors, tests_run, cycles;
    assign hready = hreadyout;
    lib_logic_input_block lib_logic_input_block_inst (.mclk(mclk), .reset(reset),
        .ahbReq(ahbReq), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .contactPin(contactPin), .tripDemand(tripDemand), .closeDemand(closeDemand),
        .syncCheckOk(syncCheckOk), .simTestMode(simTestMode), .breakerClosed(breakerClosed),
        .prefaultState(prefaultState), .gateOut(gateOut));
    lib_far_model lib_far_model_inst (.mclk(mclk), .contactWant(contactWant),
        .condWant(condWant), .contactPin(contactPin), .tripDemand(tripDemand),
        .closeDemand(closeDemand), .syncCheckOk(syncCheckOk), .simTestMode(simTestMode),
        .breakerClosed(breakerClosed), .prefaultState(prefaultState));
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic test_done;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            test_done;
        end
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // address phase held until hready, then data phase held until hready again
    task automatic busXfer(input logic [11:0] a, input logic wr, input logic [31:0] wd,
        output logic [31:0] rd);
        ahbReq.hsel <= 1'b1;
        ahbReq.haddr <= {20'h00000, a};
        ahbReq.htrans <= 2'h2;
        ahbReq.hwrite <= wr;
        ahbReq.hsize <= 3'h2;
        do @(posedge mclk); while (hready !== 1'b1);
        ahbReq.hsel <= 1'b0;
        ahbReq.htrans <= 2'h0;
        ahbReq.hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        busXfer(a, 1'b1, d, r);
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        busXfer(a, 1'b0, 32'h0, r);
        check(64'(r), 64'(exp), what);
        check(64'(hresp), 64'h0, "okay");
    endtask
    // four selectors share a word, so a shadow copy keeps the neighbours intact
    task automatic setSel(input int base, input int idx, input logic [4:0] code,
        input logic [11:0] ofs);
        int b;
        b = base + 4 * (idx / 4);
        selSh[base + idx] = code;
        wrReg(12'(ofs + 4 * (idx / 4)),
            {3'h0, selSh[b + 3], 3'h0, selSh[b + 2], 3'h0, selSh[b + 1], 3'h0, selSh[b]});
    endtask
    task automatic setIn(input int n, input logic [4:0] code);
        setSel(0, n - 1, code, lib_pkg::OFS_SETUP);
    endtask
    task automatic setFn(input int f, input logic [4:0] code);
        setSel(20, f, code, lib_pkg::OFS_FSEL);
    endtask
    task automatic setVirt(input int n, input logic v);
        virtSh[n - 1] = v;
        wrReg(lib_pkg::OFS_VIRT, {12'h000, virtSh});
    endtask
    task automatic settle;
        repeat (4) @(posedge mclk);
    endtask
    task automatic wipe(input string name);
        foreach (selSh[i]) selSh[i] = 5'h00;
        virtSh = 20'h00000;
        contactWant <= 14'h0000;
        condWant <= 6'h00;
        for (int r = 0; r < 12; r++) wrReg(12'(lib_pkg::OFS_FSEL + 4 * r), 32'h0);
        for (int r = 0; r < 5; r++) wrReg(12'(lib_pkg::OFS_SETUP + 4 * r), 32'h0);
        wrReg(lib_pkg::OFS_VIRT, 32'h0);
        wrReg(lib_pkg::OFS_CTRL, 32'h0);
        settle;
        $display("test %s done", name);
    endtask
    function automatic logic expIn(input int code, input logic c, input logic v, input logic hi);
        logic cs;
        logic vs;
        cs = (code inside {1, 5, 6, 9, 10, 13, 14}) ? c : !c;
        vs = code[0] ? v : !v;
        if (code == 3 || code == 4) return code == 3 ? v : !v;
        if (hi || code == 0 || code > 16) return 1'b0;
        if (code <= 2) return cs;
        if (code <= 8) return cs & vs;
        if (code <= 12) return cs | vs;
        return cs ^ vs;
    endfunction
    task automatic testReset;
        rdChk(lib_pkg::OFS_CTRL, 32'h0, "ctrl reset");
        rdChk(lib_pkg::OFS_VIRT, 32'h0, "virt reset");
        rdChk(lib_pkg::OFS_SETUP, 32'h0, "setup reset");
        rdChk(lib_pkg::OFS_FSEL + 12'h02c, 32'h0, "fsel reset");
        wrReg(12'h0f0, 32'hffffffff);
        rdChk(12'h0f0, 32'h0, "unmapped");
        for (int n = 15; n <= 20; n++) setIn(n, 5'h03);
        virtSh = 20'hfffff;
        wrReg(lib_pkg::OFS_VIRT, 32'h000fffff);
        setFn(lib_pkg::F_OC_ALL, 5'h15);
        settle;
        rdChk(lib_pkg::OFS_LSTAT, 32'h000fc000, "inputs on");
        check(64'(gateOut), 64'h0, "all disabled");
        wipe("reset");
    endtask
    task automatic testRelays;
        for (int n = 15; n <= 17; n++) setIn(n, 5'h03);
        setFn(lib_pkg::F_TRIP, 5'h0f);
        setFn(lib_pkg::F_CLOSE, 5'h10);
        setFn(lib_pkg::F_SYNC_BYP, 5'h11);
        condWant <= 6'b111000;
        settle;
        check(64'({gateOut.tripRelay, gateOut.closeRelay}), 64'h3, "relays free");
        setVirt(15, 1'b1);
        setVirt(16, 1'b1);
        settle;
        check(64'({gateOut.tripRelay, gateOut.closeRelay}), 64'h0, "blocked");
        check(64'(gateOut.elemInhibit), 64'h0, "elements live");
        setVirt(16, 1'b0);
        condWant <= 6'b110000;
        settle;
        check(64'(gateOut.closeRelay), 64'h0, "no sync");
        setVirt(17, 1'b1);
        settle;
        check(64'(gateOut.closeRelay), 64'h1, "bypass");
        wipe("relays");
    endtask
    task automatic testMany;
        setIn(18, 5'h03);
        for (int f = lib_pkg::F_ELEM0; f <= lib_pkg::F_OC_ALL; f++) setFn(f, 5'h12);
        setVirt(18, 1'b1);
        settle;
        check(64'(gateOut.elemInhibit), 64'h1fff, "elements");
        check(64'(gateOut.breakerStatsFreeze), 64'h1, "stats");
        check(64'(gateOut.ocInhibit), 64'h3fff, "oc all");
        check(64'(gateOut.reversePowerInhibit), 64'h0, "no mod");
        rdChk(lib_pkg::OFS_FACT_LO, 32'h0001fffc, "active");
        wrReg(lib_pkg::OFS_CTRL, 32'h1);
        settle;
        check(64'(gateOut.reversePowerInhibit), 64'h1, "mod on");
        setVirt(18, 1'b0);
        repeat (2) @(posedge mclk);
        check(64'(gateOut), 64'h0, "released");
        wipe("many");
    endtask
    task automatic testGroups;
        logic [13:0] grp [4] = '{14'h000f, 14'h00f0, 14'h0300, 14'h0c00};
        logic [13:0] want;
        setIn(18, 5'h03);
        setVirt(18, 1'b1);
        for (int f = 17; f <= 34; f++)
        begin
            setFn(f, 5'h12);
            settle;
            want = f < 21 ? grp[f - 17] : 14'h0001 << (f - 21);
            check(64'(gateOut.ocInhibit), 64'(want), "oc");
            setFn(f, 5'h00);
        end
        wipe("groups");
    endtask
    task automatic testXfer;
        int fn [7] = '{lib_pkg::F_SRC1_CLOSED, lib_pkg::F_SRC2_CLOSED, lib_pkg::F_CPL_CLOSE1,
            lib_pkg::F_TIE_CLOSED, lib_pkg::F_XFMR_LOCK, lib_pkg::F_SRC_TRIP, lib_pkg::F_XFER_BLK};
        for (int i = 0; i < 8; i++) setIn(i + 2, 5'h03);
        for (int i = 0; i < 7; i++) setFn(fn[i], 5'(i + 2));
        for (int n = 2; n <= 5; n++) setVirt(n, 1'b1);
        settle;
        check(64'({gateOut.sourceBreakerClosedState, gateOut.tieClosed}), 64'h7, "state");
        check(64'(gateOut.couplerCloseRequest), 64'h1, "coupler");
        check(64'(gateOut.transferInitiate), 64'h0, "idle");
        for (int n = 6; n <= 7; n++)
        begin
            setVirt(n, 1'b1);
            settle;
            check(64'(gateOut.transferInitiate), 64'h1, "initiate");
            setVirt(n, 1'b0);
        end
        setVirt(6, 1'b1);
        setVirt(8, 1'b1);
        settle;
        check(64'({gateOut.transferInhibit, gateOut.transferInitiate,
            gateOut.couplerCloseRequest}), 64'h4, "blocked");
        setVirt(8, 1'b0);
        setFn(lib_pkg::F_TIE_CONN, 5'h09);
        settle;
        check(64'({gateOut.transferInhibit, gateOut.transferInitiate,
            gateOut.couplerCloseRequest}), 64'h4, "tie out");
        setVirt(9, 1'b1);
        settle;
        check(64'({gateOut.transferInhibit, gateOut.transferInitiate,
            gateOut.couplerCloseRequest}), 64'h3, "tie in");
        wipe("transfer");
    endtask
    task automatic testReclose;
        for (int n = 10; n <= 12; n++) setIn(n, 5'h03);
        setFn(lib_pkg::F_RC_INIT, 5'h0a);
        setFn(lib_pkg::F_RC_CANCEL, 5'h0b);
        setFn(lib_pkg::F_RC_BLOCK, 5'h0c);
        setVirt(10, 1'b1);
        settle;
        check(64'({gateOut.recloseInitiate, gateOut.recloseAbort}), 64'h2, "rc");
        check(64'(gateOut.tripRelay), 64'h0, "no trip");
        for (int n = 11; n <= 12; n++)
        begin
            setVirt(n, 1'b1);
            settle;
            check(64'({gateOut.recloseInitiate, gateOut.recloseAbort}), 64'h1, "abort");
            setVirt(n, 1'b0);
        end
        wipe("reclose");
    endtask
    task automatic testFault;
        setIn(13, 5'h03);
        setFn(lib_pkg::F_SIM_FAULT, 5'h0d);
        condWant <= 6'h07;
        setVirt(13, 1'b1);
        settle;
        check(64'(gateOut.faultForce), 64'h1, "fault");
        for (int i = 0; i < 3; i++)
        begin
            condWant <= 6'h07 ^ (6'h01 << i);
            settle;
            check(64'(gateOut.faultForce), 64'h0, "fault gated");
        end
        wipe("fault");
    endtask
    task automatic testLogic;
        for (int code = 0; code <= 16; code++)
            for (int cv = 0; cv < 4; cv++)
            begin
                contactWant <= {13'h0000, cv[1]};
                setVirt(1, cv[0]);
                setVirt(15, cv[0]);
                setIn(1, 5'(code));
                setIn(15, 5'(code));
                repeat (8) @(posedge mclk);
                rdChk(lib_pkg::OFS_LSTAT, {17'h0, expIn(code, 1'b1, cv[0], 1'b1), 13'h0,
                    expIn(code, cv[1], cv[0], 1'b0)}, "input state");
            end
        setIn(1, 5'h1f);
        repeat (4) @(posedge mclk);
        rdChk(lib_pkg::OFS_LSTAT, 32'h0, "code off range");
        wipe("logic");
    endtask
    initial
    begin
        reset = 1'b1;
        ahbReq = '0;
        contactWant = 14'h0000;
        condWant = 6'h00;
        errors = 0;
        tests_run = 0;
        cycles = 0;
        virtSh = 20'h00000;
        foreach (selSh[i]) selSh[i] = 5'h00;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        testReset;
        testRelays;
        testMany;
        testGroups;
        testXfer;
        testReclose;
        testFault;
        testLogic;
        test_done;
    end
endmodule // testbench
`default_nettype wire
